// [core/rcsm_linestate.sv]
// Symbol pair run detector: classifies received symbol pairs into
// line states by counting consecutive matching pairs.
// Assumes pair_valid and pair come from core_clk logic.
`include "rcsm_params.svh"
module rcsm_linestate
	import rcsm_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       pair_valid,
	input  wire logic [9:0] pair,
	output logic            idle_hit,
	output logic            super_hit,
	output logic            jk_hit,
	output logic            quiet_hit,
	output logic            halt_hit,
	output logic            master_hit
);

	logic [9:0] last_q;        // Previous pair code
	logic [9:0] last_d;
	logic [3:0] run_q;         // Run length, saturates
	logic [3:0] run_d;

	// ------------------------------------------------------------------
	// Run counting, saturating at 15, above the longest run of interest
	// ------------------------------------------------------------------
	always_comb begin
		last_d = last_q;
		run_d  = run_q;
		if (pair_valid) begin
			last_d = pair;
			if (pair != last_q || run_q == 4'h0) begin
				run_d = 4'h1;
			end else if (run_q != 4'hF) begin
				run_d = run_q + 4'h1;
			end
		end
	end

	// Hits are pulses when a pair arrives and, except for jk_hit, the run qualifies
	always_comb begin
		idle_hit   = pair_valid && pair == `RCSM_SYM_IDLE
			&& run_d >= `RCSM_IDLE_RUN;
		super_hit  = pair_valid && pair == `RCSM_SYM_IDLE
			&& run_d >= `RCSM_SUPER_RUN;
		jk_hit     = pair_valid && pair == `RCSM_SYM_JK;
		quiet_hit  = pair_valid && pair == `RCSM_SYM_QUIET
			&& run_d >= `RCSM_LONG_RUN;
		halt_hit   = pair_valid && pair == `RCSM_SYM_HALT
			&& run_d >= `RCSM_LONG_RUN;
		master_hit = pair_valid && pair == `RCSM_SYM_MASTER
			&& run_d >= `RCSM_LONG_RUN;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			last_q <= 10'h000;
			run_q  <= 4'h0;
		end else begin
			last_q <= last_d;
			run_q  <= run_d;
		end
	end

endmodule // rcsm_linestate

// [core/rcsm_params.svh]
// Register offsets, field positions, reset values and timing counts
// for the receive condition status and mask block.
// Assumes inclusion by bare name from the modules.
`ifndef RCSM_PARAMS_SVH
`define RCSM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets on the control bus
// ----------------------------------------------------------------------
`define RCSM_ADDR_COND_A     5'h09
`define RCSM_ADDR_COND_B     5'h0A
`define RCSM_ADDR_MASK_A     5'h0B
`define RCSM_ADDR_MASK_B     5'h0C

// ----------------------------------------------------------------------
// Condition register B field positions
// ----------------------------------------------------------------------
`define RCSM_B_IDLE          0
`define RCSM_B_STHR          1
`define RCSM_B_ACTIVE        2
`define RCSM_B_UNK_VALID     3
`define RCSM_B_CASC_ERR      4
`define RCSM_B_BUF_FAULT     5
`define RCSM_B_SUPER_IDLE    6
`define RCSM_B_SPARE         7

// ----------------------------------------------------------------------
// Condition register A field positions
// ----------------------------------------------------------------------
`define RCSM_A_NO_SIGNAL     0
`define RCSM_A_QUIET         1
`define RCSM_A_HALT          2
`define RCSM_A_MASTER        3
`define RCSM_A_NOISE         4
`define RCSM_A_NOISE_THR     5
`define RCSM_A_CHANGE        6
`define RCSM_A_UNK_INVALID   7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCSM_MASK_RESET      8'h00
`define RCSM_COND_B_RESET    8'h02
`define RCSM_COND_A_RESET    8'h20

// ----------------------------------------------------------------------
// Symbol pair codes and run lengths
// ----------------------------------------------------------------------
`define RCSM_SYM_IDLE        10'h3FF
`define RCSM_SYM_JK          10'h311
`define RCSM_SYM_QUIET       10'h000
`define RCSM_SYM_HALT        10'h084
`define RCSM_SYM_MASTER      10'h080
`define RCSM_IDLE_RUN        4'h2
`define RCSM_SUPER_RUN       4'h8
`define RCSM_LONG_RUN        4'h8

// ----------------------------------------------------------------------
// Cascade start window
// ----------------------------------------------------------------------
`define RCSM_CLK_NS          10
`define RCSM_CASC_WIN_NS     80
`define RCSM_CASC_WIN_CYC    ((`RCSM_CASC_WIN_NS) / (`RCSM_CLK_NS))

`endif

// [core/rcsm_pkg.sv]
// Types shared by the receive condition status and mask block.
// Assumes the constants header sits beside it in core/.
package rcsm_pkg;

	// ------------------------------------------------------------------
	// Line state classes seen by the condition logic
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		RCSM_LS_NONE,
		RCSM_LS_NO_SIGNAL,
		RCSM_LS_QUIET,
		RCSM_LS_HALT,
		RCSM_LS_MASTER,
		RCSM_LS_NOISE,
		RCSM_LS_IDLE,
		RCSM_LS_ACTIVE,
		RCSM_LS_UNKNOWN
	} rcsm_ls_t;

	// Cascade watch states
	typedef enum logic [1:0] {
		RCSM_CW_IDLE,
		RCSM_CW_WAIT,
		RCSM_CW_DONE
	} rcsm_cw_t;

	typedef logic [7:0] rcsm_byte_t;

endpackage : rcsm_pkg

// [core/rcsm_sync.sv]
// Two-flop synchroniser for a group of level inputs.
// Assumes inputs are from outside the core_clk domain.
`include "rcsm_params.svh"
module rcsm_sync
	import rcsm_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// First stage; read only by the second stage
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_d;

	// ------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= meta_d;
			sync_out <= sync_d;
		end
	end

endmodule // rcsm_sync

// [core/rcsm_top.sv]
// Receive condition registers A and B with masks A and B, driving the
// two summary bits of the interrupt condition register.
// Assumes a simple synchronous register port on core_clk, decoded
// symbol pairs from the receiver and event pulses from sibling logic.
`include "rcsm_params.svh"
module rcsm_top
	import rcsm_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [4:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            reg_rvalid,
	input  wire logic       pair_valid,
	input  wire logic [9:0] pair,
	input  wire logic       no_signal_det,
	input  wire logic       noise_state,
	input  wire logic       unknown_state,
	input  wire logic       line_change,
	input  wire logic       state_cnt_zero,
	input  wire logic       state_thr_loaded,
	input  wire logic       noise_cnt_zero,
	input  wire logic       noise_thr_loaded,
	input  wire logic       buf_fault,
	input  wire logic       cascade_rdy,
	input  wire logic       cascade_start,
	output logic            cond_a_summary,
	output logic            cond_b_summary
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	rcsm_byte_t cond_reg_a_q;      // Condition register A
	rcsm_byte_t cond_reg_a_d;
	rcsm_byte_t cond_reg_b_q;      // Condition register B
	rcsm_byte_t cond_reg_b_d;
	rcsm_byte_t cond_mask_a_q;     // Mask register A
	rcsm_byte_t cond_mask_a_d;
	rcsm_byte_t cond_mask_b_q;     // Mask register B
	rcsm_byte_t cond_mask_b_d;
	rcsm_byte_t set_a;             // Hardware set terms, A
	rcsm_byte_t set_b;             // Hardware set terms, B
	rcsm_byte_t clr_a;             // Software clear terms, A
	rcsm_byte_t clr_b;             // Software clear terms, B
	rcsm_ls_t   ls_q;              // Current line state
	rcsm_ls_t   ls_d;
	rcsm_ls_t   known_q;           // Last known line state
	rcsm_ls_t   known_d;
	logic       sthr_armed_q;      // Threshold reload seen since set
	logic       sthr_armed_d;
	logic       nthr_armed_q;      // Noise reload seen since set
	logic       nthr_armed_d;
	rcsm_cw_t   cw_q;              // Cascade watch state
	rcsm_cw_t   cw_d;
	logic [3:0] cw_cnt_q;          // Cascade window count
	logic [3:0] cw_cnt_d;
	logic       casc_rdy_old_q;    // Delayed ready for edge detect
	logic       casc_err_evt;
	logic [7:0] rdata_d;
	logic       rvalid_d;
	logic       sum_a_d;
	logic       sum_b_d;
	logic       idle_hit;
	logic       super_hit;
	logic       jk_hit;
	logic       quiet_hit;
	logic       halt_hit;
	logic       master_hit;
	logic [1:0] casc_sync;         // Synchronised cascade pins

	// Address match, used by every register's write path
	function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
		return a == r;
	endfunction

	// ------------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------------
	// Cascade pins come from another device, so they are synchronised
	rcsm_sync #(
		.WIDTH    (2)
	) u_casc_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in ({cascade_start, cascade_rdy}),
		.sync_out (casc_sync)
	);

	rcsm_linestate u_ls (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.pair_valid (pair_valid),
		.pair       (pair),
		.idle_hit   (idle_hit),
		.super_hit  (super_hit),
		.jk_hit     (jk_hit),
		.quiet_hit  (quiet_hit),
		.halt_hit   (halt_hit),
		.master_hit (master_hit)
	);

	// ------------------------------------------------------------------
	// Line state tracking
	// ------------------------------------------------------------------
	// Priority: loss of signal over pair runs over sibling classes
	always_comb begin
		ls_d    = ls_q;
		known_d = known_q;
		if (no_signal_det) begin
			ls_d = RCSM_LS_NO_SIGNAL;
		end else if (jk_hit) begin
			ls_d = RCSM_LS_ACTIVE;
		end else if (idle_hit) begin
			ls_d = RCSM_LS_IDLE;
		end else if (quiet_hit) begin
			ls_d = RCSM_LS_QUIET;
		end else if (halt_hit) begin
			ls_d = RCSM_LS_HALT;
		end else if (master_hit) begin
			ls_d = RCSM_LS_MASTER;
		end else if (noise_state) begin
			ls_d = RCSM_LS_NOISE;
		end else if (unknown_state) begin
			ls_d = RCSM_LS_UNKNOWN;
		end
		// Track the state being entered, so a known state lasting one
		// cycle is still seen when the line goes unknown right after
		if (ls_d != RCSM_LS_UNKNOWN && ls_d != RCSM_LS_NONE) begin
			known_d = ls_d;
		end
	end

	// ------------------------------------------------------------------
	// Cascade synchronisation watch
	// ------------------------------------------------------------------
	// Release of ready opens a window; start must arrive inside it
	always_comb begin
		cw_d         = cw_q;
		cw_cnt_d     = cw_cnt_q;
		casc_err_evt = 1'b0;
		unique case (cw_q)
			RCSM_CW_IDLE: begin
				if (casc_rdy_old_q && !casc_sync[0]) begin
					cw_d     = RCSM_CW_WAIT;
					cw_cnt_d = 4'h0;
				end
			end
			RCSM_CW_WAIT: begin
				if (casc_sync[1]) begin
					cw_d = RCSM_CW_DONE;
				end else if (cw_cnt_q >= 4'(`RCSM_CASC_WIN_CYC)) begin
					casc_err_evt = 1'b1;
					cw_d         = RCSM_CW_DONE;
				end else begin
					cw_cnt_d = cw_cnt_q + 4'h1;
				end
			end
			RCSM_CW_DONE: begin
				// Rearm once ready is asserted again
				if (casc_sync[0]) begin
					cw_d = RCSM_CW_IDLE;
				end
			end
			// Unused fourth code of the two-bit state
			default: begin
				cw_d = RCSM_CW_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Set and clear terms for the condition registers
	// ------------------------------------------------------------------
	always_comb begin
		set_a = 8'h00;
		set_b = 8'h00;
		// Entering a state sets its bit; nothing here ever clears one
		if (ls_d != ls_q) begin
			unique case (ls_d)
				RCSM_LS_NO_SIGNAL: set_a[`RCSM_A_NO_SIGNAL] = 1'b1;
				RCSM_LS_QUIET:     set_a[`RCSM_A_QUIET]     = 1'b1;
				RCSM_LS_HALT:      set_a[`RCSM_A_HALT]      = 1'b1;
				RCSM_LS_MASTER:    set_a[`RCSM_A_MASTER]    = 1'b1;
				RCSM_LS_NOISE:     set_a[`RCSM_A_NOISE]     = 1'b1;
				RCSM_LS_IDLE:      set_b[`RCSM_B_IDLE]      = 1'b1;
				RCSM_LS_ACTIVE:    set_b[`RCSM_B_ACTIVE]    = 1'b1;
				RCSM_LS_UNKNOWN: begin
					// Valid or invalid depends on the last known state
					if (known_q == RCSM_LS_ACTIVE
						|| known_q == RCSM_LS_IDLE) begin
						set_b[`RCSM_B_UNK_VALID] = 1'b1;
					end else begin
						set_a[`RCSM_A_UNK_INVALID] = 1'b1;
					end
				end
				default: ;
			endcase
			set_a[`RCSM_A_CHANGE] = 1'b1;
		end
		// Super idle is a longer idle run, not a separate state
		set_b[`RCSM_B_SUPER_IDLE] = super_hit;
		set_b[`RCSM_B_STHR]       = state_cnt_zero;
		set_b[`RCSM_B_CASC_ERR]   = casc_err_evt;
		set_b[`RCSM_B_BUF_FAULT]  = buf_fault;
		set_a[`RCSM_A_NOISE_THR]  = noise_cnt_zero;
		// Spare bit has no hardware source
		set_b[`RCSM_B_SPARE]      = 1'b0;
	end

	// Write of 0 clears, write of 1 keeps; threshold bits need a reload
	always_comb begin
		clr_a = 8'h00;
		clr_b = 8'h00;
		if (reg_wr && hit(reg_addr, `RCSM_ADDR_COND_A)) begin
			clr_a = ~reg_wdata;
			if (!nthr_armed_q) begin
				clr_a[`RCSM_A_NOISE_THR] = 1'b0;
			end
		end
		if (reg_wr && hit(reg_addr, `RCSM_ADDR_COND_B)) begin
			clr_b = ~reg_wdata;
			if (!sthr_armed_q) begin
				clr_b[`RCSM_B_STHR] = 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Register next values
	// ------------------------------------------------------------------
	always_comb begin
		// Set wins over a clear in the same cycle
		cond_reg_a_d  = (cond_reg_a_q & ~clr_a) | set_a;
		cond_reg_b_d  = (cond_reg_b_q & ~clr_b) | set_b;
		cond_mask_a_d = cond_mask_a_q;
		cond_mask_b_d = cond_mask_b_q;
		if (reg_wr && hit(reg_addr, `RCSM_ADDR_MASK_A)) begin
			cond_mask_a_d = reg_wdata;
		end
		if (reg_wr && hit(reg_addr, `RCSM_ADDR_MASK_B)) begin
			cond_mask_b_d = reg_wdata;
		end
		// Reload arms the clear; a new zero count disarms it
		sthr_armed_d = (sthr_armed_q || state_thr_loaded)
			&& !state_cnt_zero;
		nthr_armed_d = (nthr_armed_q || noise_thr_loaded)
			&& !noise_cnt_zero;
		if (reg_wr && hit(reg_addr, `RCSM_ADDR_COND_B)
			&& !reg_wdata[`RCSM_B_STHR]) begin
			sthr_armed_d = 1'b0;
		end
		if (reg_wr && hit(reg_addr, `RCSM_ADDR_COND_A)
			&& !reg_wdata[`RCSM_A_NOISE_THR]) begin
			nthr_armed_d = 1'b0;
		end
		// Summaries use the next values so they track the registers
		sum_a_d = |(cond_reg_a_d & cond_mask_a_d);
		sum_b_d = |(cond_reg_b_d & cond_mask_b_d);
	end

	// Read port: one cycle latency, unmapped reads return zero
	always_comb begin
		rvalid_d = reg_rd;
		rdata_d  = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`RCSM_ADDR_COND_A: rdata_d = cond_reg_a_q;
				`RCSM_ADDR_COND_B: rdata_d = cond_reg_b_q;
				`RCSM_ADDR_MASK_A: rdata_d = cond_mask_a_q;
				`RCSM_ADDR_MASK_B: rdata_d = cond_mask_b_q;
				default:           rdata_d = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// Counters start at zero, so threshold bits come up set
			cond_reg_a_q   <= `RCSM_COND_A_RESET;
			cond_reg_b_q   <= `RCSM_COND_B_RESET;
			cond_mask_a_q  <= `RCSM_MASK_RESET;
			cond_mask_b_q  <= `RCSM_MASK_RESET;
			ls_q           <= RCSM_LS_NONE;
			known_q        <= RCSM_LS_NONE;
			sthr_armed_q   <= 1'b0;
			nthr_armed_q   <= 1'b0;
			cw_q           <= RCSM_CW_IDLE;
			cw_cnt_q       <= 4'h0;
			casc_rdy_old_q <= 1'b0;
			reg_rdata      <= 8'h00;
			reg_rvalid     <= 1'b0;
			cond_a_summary <= 1'b0;
			cond_b_summary <= 1'b0;
		end else begin
			cond_reg_a_q   <= cond_reg_a_d;
			cond_reg_b_q   <= cond_reg_b_d;
			cond_mask_a_q  <= cond_mask_a_d;
			cond_mask_b_q  <= cond_mask_b_d;
			ls_q           <= ls_d;
			known_q        <= known_d;
			sthr_armed_q   <= sthr_armed_d;
			nthr_armed_q   <= nthr_armed_d;
			cw_q           <= cw_d;
			cw_cnt_q       <= cw_cnt_d;
			casc_rdy_old_q <= casc_sync[0];
			reg_rdata      <= rdata_d;
			reg_rvalid     <= rvalid_d;
			cond_a_summary <= sum_a_d;
			cond_b_summary <= sum_b_d;
		end
	end

endmodule // rcsm_top

// [sim/rcsm_assertions.sv]
// Port-level checker for the receive condition status and mask block.
// Assumes it is bound onto rcsm_top and sees only that module's ports.
`include "rcsm_params.svh"
module rcsm_assertions
	import rcsm_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       nrst,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       reg_rvalid,
	input wire logic       pair_valid,
	input wire logic [9:0] pair,
	input wire logic       no_signal_det,
	input wire logic       state_cnt_zero,
	input wire logic       buf_fault,
	input wire logic       cascade_rdy,
	input wire logic       cascade_start,
	input wire logic       cond_a_summary,
	input wire logic       cond_b_summary
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------------
	// Shadow masks, rebuilt from register writes
	// ------------------------------------------------------------------
	rcsm_byte_t mask_a_q, mask_a_d; // Mask A as last written
	rcsm_byte_t mask_b_q, mask_b_d; // Mask B as last written

	// Next values: only a write to the mask offset moves them
	always_comb begin
		mask_a_d = mask_a_q;
		mask_b_d = mask_b_q;
		if (reg_wr && reg_addr == `RCSM_ADDR_MASK_A) begin
			mask_a_d = reg_wdata;
		end
		if (reg_wr && reg_addr == `RCSM_ADDR_MASK_B) begin
			mask_b_d = reg_wdata;
		end
	end

	// Zero at reset, like the real masks
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mask_a_q <= 8'h00;
			mask_b_q <= 8'h00;
		end else begin
			mask_a_q <= mask_a_d;
			mask_b_q <= mask_b_d;
		end
	end

	// ------------------------------------------------------------------
	// Line sequences
	// ------------------------------------------------------------------
	sequence idle_pair;
		pair_valid && pair == `RCSM_SYM_IDLE;
	endsequence
	sequence casc_late;
		$fell(cascade_rdy) ##1 (!cascade_rdy && !cascade_start) [*8];
	endsequence

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read got no answer");
	mask_b_read_a: assert property (
		reg_rd && reg_addr == `RCSM_ADDR_MASK_B
		|=> reg_rdata == mask_b_q)
		else $error("mask B read back wrong");
	no_mask_b_a: assert property (
		mask_b_q == 8'h00 |-> !cond_b_summary)
		else $error("B summary with mask B clear");
	idle_sets_a: assert property (
		idle_pair [*2] ##0 (mask_b_q[0] && !reg_wr)
		|=> cond_b_summary)
		else $error("idle run gave no B summary");
	super_idle_a: assert property (
		idle_pair [*8] ##0 (mask_b_q[6] && !reg_wr)
		|=> cond_b_summary)
		else $error("long idle run gave no B summary");
	jk_active_a: assert property (
		pair_valid && pair == `RCSM_SYM_JK && mask_b_q[2] && !reg_wr
		|=> cond_b_summary)
		else $error("start pair gave no B summary");
	thr_event_a: assert property (
		state_cnt_zero && mask_b_q[1] && !reg_wr |=> cond_b_summary)
		else $error("threshold event gave no B summary");
	buf_fault_a: assert property (
		buf_fault && mask_b_q[5] && !reg_wr |=> cond_b_summary)
		else $error("buffer fault gave no B summary");
	casc_miss_a: assert property (
		casc_late ##0 mask_b_q[4] |-> ##[1:8] cond_b_summary)
		else $error("missed cascade start not flagged");
	sticky_sum_a: assert property (
		$fell(cond_b_summary) |-> $past(reg_wr))
		else $error("B summary dropped without a write");
	no_signal_a: assert property (
		no_signal_det && mask_a_q[0] && !reg_wr
		|=> ##[0:2] cond_a_summary)
		else $error("signal loss gave no A summary");
endmodule // rcsm_assertions

// [sim/rcsm_mgr_model.sv]
// Management processor model driving the block's register port.
// Assumes requests are taken on the rising core_clk edge.
module rcsm_mgr_model
	import rcsm_pkg::*;
(
	input  wire logic       core_clk,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [4:0] reg_addr,
	output rcsm_byte_t      reg_wdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle bus at time zero
	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 5'h00;
		reg_wdata = 8'h00;
	end

	// One-cycle write; zeros clear flags, ones keep them
	task automatic wr(input logic [4:0] a, input rcsm_byte_t d);
		@(negedge core_clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge core_clk);
		reg_wr    = 1'b0;
		reg_wdata = ~d;
	endtask

	// One-cycle read; data is checked by the bench monitor
	task automatic rd(input logic [4:0] a);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge core_clk);
		reg_rd   = 1'b0;
		reg_addr = ~a;
	endtask
endmodule // rcsm_mgr_model

// [sim/test_receive_condition_status_mask.sv]
// Self-checking bench for the receive condition status and mask block.
// Assumes the management model and checker files from sim/.
`include "rcsm_params.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
	num_errors++; $display("[ERR] %0t got %h want %h", $time, got, exp); \
	end end
module test_receive_condition_status_mask
	import rcsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------------
	// Signals and bookkeeping
	// ------------------------------------------------------------------
	logic core_clk, nrst, reg_wr, reg_rd, reg_rvalid, pair_valid;
	logic no_signal_det, unknown_state, state_cnt_zero, state_thr_loaded;
	logic noise_state, noise_cnt_zero;
	logic noise_thr_loaded, buf_fault, cascade_rdy, cascade_start;
	logic cond_a_summary, cond_b_summary;
	logic [4:0] reg_addr;
	logic [9:0] pair;
	rcsm_byte_t reg_wdata, reg_rdata, e, r;
	rcsm_byte_t exp_q[$]; // Expected read data, oldest first
	int         num_errors, checks, cyc;
	logic [9:0] codes[3] = '{`RCSM_SYM_QUIET, `RCSM_SYM_HALT,
		`RCSM_SYM_MASTER};

	rcsm_mgr_model mgr (.core_clk(core_clk), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	// Change hint is derived inside the block, so it is tied off
	rcsm_top DUT (.core_clk(core_clk), .nrst(nrst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.pair_valid(pair_valid), .pair(pair),
		.no_signal_det(no_signal_det), .noise_state(noise_state),
		.unknown_state(unknown_state), .line_change(1'b0),
		.state_cnt_zero(state_cnt_zero),
		.state_thr_loaded(state_thr_loaded),
		.noise_cnt_zero(noise_cnt_zero),
		.noise_thr_loaded(noise_thr_loaded), .buf_fault(buf_fault),
		.cascade_rdy(cascade_rdy), .cascade_start(cascade_start),
		.cond_a_summary(cond_a_summary), .cond_b_summary(cond_b_summary));

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Monitor: each answer consumes the oldest note; empty queue fails
	always @(negedge core_clk) begin
		cyc++;
		if (reg_rvalid === 1'b1) begin
			e = exp_q.size() ? exp_q.pop_front() : 8'hXX;
			`CHK(reg_rdata, e)
		end
		if (cyc == 2000) begin
			num_errors++;
			close_out();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic rd(input logic [4:0] a, input rcsm_byte_t x);
		exp_q.push_back(x);
		mgr.rd(a);
	endtask

	// Back-to-back pairs of one code, then the line goes invalid
	task automatic pairs(input logic [9:0] c, input int n);
		repeat (n) begin
			@(negedge core_clk);
			pair_valid = 1'b1;
			pair       = c;
		end
		@(negedge core_clk);
		pair_valid = 1'b0;
		pair       = ~c;
	endtask

	// Event input held for n cycles
	task automatic pulse(ref logic s, input int n);
		@(negedge core_clk);
		s = 1'b1;
		repeat (n) @(negedge core_clk);
		s = 1'b0;
	endtask

	task automatic close_out();
		`CHK(exp_q.size(), 0)
		if (num_errors == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'h63BC6CBA));
		{nrst, pair_valid, no_signal_det, unknown_state} = 4'h0;
		{state_cnt_zero, state_thr_loaded, noise_thr_loaded} = 3'h0;
		{buf_fault, cascade_start, cascade_rdy, pair} = 13'h0400;
		{noise_state, noise_cnt_zero} = 2'h0;
		repeat (2) @(negedge core_clk);
		nrst = 1'b1;
		rd(`RCSM_ADDR_COND_B, 8'h02);
		rd(`RCSM_ADDR_COND_A, 8'h20);
		rd(`RCSM_ADDR_MASK_A, 8'h00);
		rd(`RCSM_ADDR_MASK_B, 8'h00);
		rd(5'h0D + 5'($urandom_range(18)), 8'h00);
		// Threshold flags hold until a reload is seen
		mgr.wr(`RCSM_ADDR_COND_B, 8'h00);
		rd(`RCSM_ADDR_COND_B, 8'h02);
		pulse(state_thr_loaded, 1);
		mgr.wr(`RCSM_ADDR_COND_B, 8'h00);
		rd(`RCSM_ADDR_COND_B, 8'h00);
		pulse(noise_thr_loaded, 1);
		mgr.wr(`RCSM_ADDR_COND_A, 8'h00);
		rd(`RCSM_ADDR_COND_A, 8'h00);
		// Masks
		r = rcsm_byte_t'($urandom());
		mgr.wr(`RCSM_ADDR_MASK_A, r);
		rd(`RCSM_ADDR_MASK_A, r);
		mgr.wr(`RCSM_ADDR_MASK_A, 8'h01);
		mgr.wr(`RCSM_ADDR_MASK_B, 8'h7F);
		rd(`RCSM_ADDR_MASK_B, 8'h7F);
		// Idle, active, super idle, unknown after idle
		pairs(`RCSM_SYM_IDLE, 1);
		rd(`RCSM_ADDR_COND_B, 8'h00);
		`CHK(cond_b_summary, 1'b0)
		pairs(`RCSM_SYM_IDLE, 2);
		rd(`RCSM_ADDR_COND_B, 8'h01);
		`CHK(cond_b_summary, 1'b1)
		mgr.wr(`RCSM_ADDR_COND_B, 8'h00);
		pairs(`RCSM_SYM_JK, 1);
		pairs(`RCSM_SYM_IDLE, 7);
		rd(`RCSM_ADDR_COND_B, 8'h05);
		pairs(`RCSM_SYM_JK, 1);
		pairs(`RCSM_SYM_IDLE, 8);
		rd(`RCSM_ADDR_COND_B, 8'h45);
		pulse(unknown_state, 3);
		rd(`RCSM_ADDR_COND_B, 8'h4D);
		r = rcsm_byte_t'($urandom());
		mgr.wr(`RCSM_ADDR_COND_B, r);
		rd(`RCSM_ADDR_COND_B, 8'h4D & r);
		mgr.wr(`RCSM_ADDR_COND_B, 8'hFF);
		rd(`RCSM_ADDR_COND_B, 8'h4D & r);
		// Counter and buffer events
		mgr.wr(`RCSM_ADDR_COND_B, 8'h00);
		`CHK(cond_b_summary, 1'b0)
		pulse(state_cnt_zero, 1);
		pulse(buf_fault, 1);
		rd(`RCSM_ADDR_COND_B, 8'h22);
		// Cascade start missed, then made in time
		pulse(state_thr_loaded, 1);
		mgr.wr(`RCSM_ADDR_COND_B, 8'h00);
		cascade_rdy = 1'b0;
		repeat (20) @(negedge core_clk);
		rd(`RCSM_ADDR_COND_B, 8'h10);
		cascade_rdy = 1'b1;
		mgr.wr(`RCSM_ADDR_COND_B, 8'h00);
		cascade_rdy = 1'b0;
		repeat (2) @(negedge core_clk);
		pulse(cascade_start, 4);
		repeat (16) @(negedge core_clk);
		rd(`RCSM_ADDR_COND_B, 8'h00);
		// Register A states
		mgr.wr(`RCSM_ADDR_COND_A, 8'h00);
		pulse(no_signal_det, 3);
		rd(`RCSM_ADDR_COND_A, 8'h41);
		`CHK(cond_a_summary, 1'b1)
		for (int i = 0; i < 3; i++) begin
			mgr.wr(`RCSM_ADDR_COND_A, 8'h00);
			pairs(codes[i], 8);
			rd(`RCSM_ADDR_COND_A, 8'h40 | (8'h02 << i));
		end
		// Noise state, noise threshold, then unknown after noise
		pulse(noise_state, 2);
		pulse(noise_cnt_zero, 1);
		pulse(unknown_state, 2);
		rd(`RCSM_ADDR_COND_A, 8'hF8);
		repeat (3) @(negedge core_clk);
		close_out();
	end
endmodule // test_receive_condition_status_mask

bind rcsm_top rcsm_assertions chk (.core_clk(core_clk), .nrst(nrst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.pair_valid(pair_valid), .pair(pair), .no_signal_det(no_signal_det),
	.state_cnt_zero(state_cnt_zero), .buf_fault(buf_fault),
	.cascade_rdy(cascade_rdy), .cascade_start(cascade_start),
	.cond_a_summary(cond_a_summary), .cond_b_summary(cond_b_summary));
